// >>> src/pcmtss_pkg.sv
// Purpose: Constants and types shared by the PCM time-slot switch.
// Assumes: 100 MHz clock, 8 serial lines of 128 slots, one bit per clock.
// Notes: Register offsets are byte addresses on a 32-bit Avalon-MM bus.
package pcmtss_pkg;
   // ==========================================================
   // Geometry
   localparam int LINES = 8;
   localparam int CHANNELS = 1024;
   localparam logic [9:0] FRAME_LAST = 10'h3ff;
   localparam logic [2:0] BIT_LAST = 3'h7;
   // ==========================================================
   // Register map and fields
   localparam logic [4:0] ADDR_MODE = 5'h00;
   localparam logic [4:0] ADDR_STATUS = 5'h04;
   localparam logic [4:0] ADDR_CMD = 5'h08;
   localparam logic [4:0] ADDR_IAP = 5'h0c;
   localparam logic [4:0] ADDR_EVAL = 5'h10;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam int MODE_OUT_ENABLE = 7;
   localparam int MODE_SINGLE_STORE = 6;
   localparam int STAT_SYNCED = 0;
   localparam int STAT_SYNC_CHANGE = 1;
   localparam int STAT_IAP_PARTIAL = 2;
   localparam int STAT_BUSY = 3;
   localparam int STAT_TEST_OK = 4;
   localparam int STAT_EVAL_DONE = 5;
   localparam logic [1:0] CMD_MAP_CLEAR = 2'h1;
   localparam logic [1:0] CMD_SELF_TEST = 2'h2;
   localparam logic [1:0] CMD_FRAME_EVAL = 2'h3;
   localparam int CMD_TEST_STORE = 2;
   localparam logic [3:0] CFG_OUT_SHIFT = 4'h8;
   localparam logic [7:0] TEST_PATTERN = 8'ha5;
   // ==========================================================
   // Capacity modes: 0 = 512x256, 1 = 1024x512, 2 = 1024x1024
   localparam logic [1:0] CAP_SMALL = 2'h0;
   localparam logic [1:0] CAP_HALF = 2'h1;
   localparam logic [7:0] IN_MASK_SMALL = 8'h0f;
   localparam logic [7:0] OUT_MASK_SMALL = 8'h03;
   localparam logic [7:0] OUT_MASK_HALF = 8'h0f;
   localparam logic [7:0] MASK_ALL = 8'hff;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int SELF_TEST_TIME_NS = 625000;
   localparam int SELF_TEST_CYCLES = SELF_TEST_TIME_NS / CLK_PERIOD_NS;
   typedef enum logic [2:0] {
      pcmtss_idle, pcmtss_clear, pcmtss_twrite, pcmtss_tread, pcmtss_twait
   } pcmtss_proc_t;
endpackage : pcmtss_pkg

// >>> src/pcmtss_switch.sv
// Purpose: Memory time switch core with slot map, two frame stores and host port.
// Assumes: pcm_in, frame_sync_pulse and frame_measure_input are asynchronous pins.
// Notes: One bit per clock per line; a frame is 1024 clocks.
// Functional notes
// - Any of 1024 input slots can reach any of 1024 output slots each frame.
// - Half mode maps 1024 inputs to 512 outputs; full mode maps all 1024.
// - Small mode gives 512 by 256 slots and keeps frame integrity.
// - Eight per-line shift values; each applies to its data line only, not to the paired measure line.
// - A new input offset takes effect only at the frame boundary, no bit error.
// - Memories are reached only through the byte-wide host register port.
// - Input counter writes a frame's 1024 bytes (512 in small mode) in order into a frame store unless a clear, self-test or host store write takes that cycle.
// - Single-store mode uses one store; otherwise input frames alternate stores.
// - Output counter walks slot map; each entry picks the byte sent in that slot.
// - Delay select 0 reads the store not named by the output-side pointer.
// - Delay select 1 compares source with input position to choose store.
// - Input pointers follow the input frame; output pointer follows output frame.
// - Sync starts on rising sync edge, sampled on the falling clock edge.
// - Eight extra lines serve as frame measurement inputs, one per port.
// - Evaluate command with port 0..7 captures input counter into 12 bits.
// - Frame length is checked against sync; loss or gain raises an event.
// - One output shift applies equally to all output lines.
// - Unused output ports float; slots with tristate bit set float too.
// - Five direct registers; everything else via a three-byte indirect access.
// - Slot-map clear command leaves every entry tristated.
// - Each self-test runs on the one frame store chosen by command bit 2, for a fixed duration.
// - Self-test completion reports pass or fail and clears the slot map.
// - Indirect access is three byte writes; operation starts after the third.
`timescale 1ns/1ps
module pcmtss_switch #(
   parameter int SELF_TEST_CYCLES = pcmtss_pkg::SELF_TEST_CYCLES
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic [7:0] pcm_in,
   input wire logic [7:0] frame_measure_input,
   input wire logic frame_sync_pulse,
   output logic [7:0] pcm_out,
   output logic [7:0] pcm_out_oe,
   output logic sync_change_pulse
);
   // ==========================================================
   // Avalon slave: one wait cycle, then answer
   logic ack_q, wr_en;
   logic [31:0] readdata_q;
   logic [7:0] wbyte, mode_q, status_w, iap_rd_q;
   logic [11:0] eval_q;
   assign waitrequest = (read | write) & ~ack_q;
   assign readdata = readdata_q;
   assign wr_en = write & ack_q & byteenable[0];
   assign wbyte = writedata[7:0];
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (read | write) & ~ack_q;
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         readdata_q <= 32'h0;
      end else if (read & ~ack_q) begin
         unique case (address)
            pcmtss_pkg::ADDR_MODE: readdata_q <= {24'h0, mode_q};
            pcmtss_pkg::ADDR_STATUS: readdata_q <= {24'h0, status_w};
            pcmtss_pkg::ADDR_IAP: readdata_q <= {24'h0, iap_rd_q};
            pcmtss_pkg::ADDR_EVAL: readdata_q <= {20'h0, eval_q};
            default: readdata_q <= 32'h0;
         endcase
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= pcmtss_pkg::MODE_RESET;
      end else if (wr_en && address == pcmtss_pkg::ADDR_MODE) begin
         mode_q <= wbyte;
      end
   end

   // ==========================================================
   // Pin synchronisers: a change counts once stages two and three agree
   logic [7:0] in_s1_q, in_s2_q, in_s3_q, in_f_q;
   logic [7:0] fm_s1_q, fm_s2_q, fm_s3_q, fm_f_q, fm_prev_q;
   logic sp_s1_q, sp_s2_q, sp_s3_q, sp_f_q, sp_prev_q;
   logic sp_rise;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         {in_s1_q, in_s2_q, in_s3_q, in_f_q} <= 32'h0;
         {fm_s1_q, fm_s2_q, fm_s3_q, fm_f_q, fm_prev_q} <= 40'h0;
      end else begin
         in_s1_q <= pcm_in;
         in_s2_q <= in_s1_q;
         in_s3_q <= in_s2_q;
         fm_s1_q <= frame_measure_input;
         fm_s2_q <= fm_s1_q;
         fm_s3_q <= fm_s2_q;
         fm_prev_q <= fm_f_q;
         for (int l = 0; l < pcmtss_pkg::LINES; l++) begin
            if (in_s2_q[l] == in_s3_q[l]) in_f_q[l] <= in_s3_q[l];
            if (fm_s2_q[l] == fm_s3_q[l]) fm_f_q[l] <= fm_s3_q[l];
         end
      end
   end

   // First sync stage on the falling edge
   always_ff @(negedge clock or negedge rst_n) begin
      if (!rst_n) sp_s1_q <= 1'b0;
      else sp_s1_q <= frame_sync_pulse;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         {sp_s2_q, sp_s3_q, sp_f_q, sp_prev_q} <= 4'h0;
      end else begin
         sp_s2_q <= sp_s1_q;
         sp_s3_q <= sp_s2_q;
         if (sp_s2_q == sp_s3_q) sp_f_q <= sp_s3_q;
         sp_prev_q <= sp_f_q;
      end
   end
   assign sp_rise = sp_f_q & ~sp_prev_q;

   // ==========================================================
   // Input counter and frame length check
   logic [9:0] in_cnt_q;
   logic synced_q, sync_chg_q, sync_evt, in_wrap;
   assign in_wrap = (in_cnt_q == pcmtss_pkg::FRAME_LAST);
   assign sync_evt = synced_q ? ((sp_rise & ~in_wrap) | (in_wrap & ~sp_rise))
                              : (sp_rise & in_wrap);
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         in_cnt_q <= 10'h0;
         synced_q <= 1'b0;
      end else begin
         if (sp_rise) in_cnt_q <= 10'h0;
         else in_cnt_q <= in_cnt_q + 10'h1;
         if (sync_evt) synced_q <= ~synced_q;
      end
   end
   assign sync_change_pulse = sync_evt;

   // ==========================================================
   // Input alignment: per-line tap applied at frame boundary
   logic [1:0] offs_q [pcmtss_pkg::LINES];
   logic [1:0] offs_act_q [pcmtss_pkg::LINES];
   logic [3:0] dly_q [pcmtss_pkg::LINES];
   logic [6:0] in_sh_q [pcmtss_pkg::LINES];
   logic [7:0] in_bit;
   genvar g;
   generate
      for (g = 0; g < pcmtss_pkg::LINES; g++) begin : g_in
         always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               dly_q[g] <= 4'h0;
               in_sh_q[g] <= 7'h0;
               offs_act_q[g] <= 2'h0;
            end else begin
               dly_q[g] <= {dly_q[g][2:0], in_f_q[g]};
               in_sh_q[g] <= {in_sh_q[g][5:0], in_bit[g]};
               if (in_wrap) offs_act_q[g] <= offs_q[g];
            end
         end
         assign in_bit[g] = dly_q[g][offs_act_q[g]];
      end
   endgenerate

   // ==========================================================
   // Frame stores and store pointers
   logic [7:0] store_q [2][pcmtss_pkg::CHANNELS];
   logic in_store_q, out_store_q, single, out_wrap;
   logic [10:0] in_pos;
   logic [7:0] in_mask, out_mask, out_shift_q;
   logic [9:0] out_cnt;
   assign single = mode_q[pcmtss_pkg::MODE_SINGLE_STORE];
   assign in_pos = {1'b0, in_cnt_q[9:3], 3'b000};
   assign out_cnt = in_cnt_q + {2'b00, out_shift_q};
   assign out_wrap = (out_cnt == pcmtss_pkg::FRAME_LAST);
   always_comb begin
      unique case (mode_q[1:0])
         pcmtss_pkg::CAP_SMALL: begin
            in_mask = pcmtss_pkg::IN_MASK_SMALL;
            out_mask = pcmtss_pkg::OUT_MASK_SMALL;
         end
         pcmtss_pkg::CAP_HALF: begin
            in_mask = pcmtss_pkg::MASK_ALL;
            out_mask = pcmtss_pkg::OUT_MASK_HALF;
         end
         default: begin
            in_mask = pcmtss_pkg::MASK_ALL;
            out_mask = pcmtss_pkg::MASK_ALL;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         in_store_q <= 1'b0;
         out_store_q <= 1'b0;
      end else begin
         if (in_wrap) in_store_q <= single ? 1'b0 : ~in_store_q;
         if (out_wrap) out_store_q <= single ? 1'b0 : ~out_store_q;
      end
   end

   // ==========================================================
   // Procedures: slot-map clear, self-test, frame evaluation
   pcmtss_pkg::pcmtss_proc_t proc_q;
   logic [16:0] pcnt_q;
   logic test_sel_q, test_ok_q, eval_arm_q, eval_done_q, cmd_wr;
   logic [2:0] eval_port_q;
   logic [9:0] pidx;
   assign cmd_wr = wr_en && address == pcmtss_pkg::ADDR_CMD;
   assign pidx = pcnt_q[9:0];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         proc_q <= pcmtss_pkg::pcmtss_idle;
         pcnt_q <= 17'h0;
         test_sel_q <= 1'b0;
         test_ok_q <= 1'b1;
      end else begin
         pcnt_q <= pcnt_q + 17'h1;
         unique case (proc_q)
            pcmtss_pkg::pcmtss_idle: begin
               pcnt_q <= 17'h0;
               if (cmd_wr && wbyte[1:0] == pcmtss_pkg::CMD_MAP_CLEAR) begin
                  proc_q <= pcmtss_pkg::pcmtss_clear;
               end else if (cmd_wr && wbyte[1:0] == pcmtss_pkg::CMD_SELF_TEST) begin
                  proc_q <= pcmtss_pkg::pcmtss_twrite;
                  test_sel_q <= wbyte[pcmtss_pkg::CMD_TEST_STORE];
                  test_ok_q <= 1'b1;
               end
            end
            pcmtss_pkg::pcmtss_clear: begin
               if (pidx == pcmtss_pkg::FRAME_LAST) proc_q <= pcmtss_pkg::pcmtss_idle;
            end
            pcmtss_pkg::pcmtss_twrite: begin
               if (pidx == pcmtss_pkg::FRAME_LAST) proc_q <= pcmtss_pkg::pcmtss_tread;
            end
            pcmtss_pkg::pcmtss_tread: begin
               if (store_q[test_sel_q][pidx] != (pidx[7:0] ^ pcmtss_pkg::TEST_PATTERN))
                  test_ok_q <= 1'b0;
               if (pidx == pcmtss_pkg::FRAME_LAST) proc_q <= pcmtss_pkg::pcmtss_twait;
            end
            pcmtss_pkg::pcmtss_twait: begin
               // Fixed duration, then the slot map is cleared as the final stage
               if (pcnt_q >= 17'(SELF_TEST_CYCLES)) begin
                  proc_q <= pcmtss_pkg::pcmtss_clear;
                  pcnt_q <= 17'h0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         eval_arm_q <= 1'b0;
         eval_port_q <= 3'h0;
         eval_q <= 12'h0;
      end else if (cmd_wr && wbyte[1:0] == pcmtss_pkg::CMD_FRAME_EVAL) begin
         eval_arm_q <= 1'b1;
         eval_port_q <= wbyte[5:3];
      end else if (eval_arm_q && synced_q && fm_f_q[eval_port_q] && !fm_prev_q[eval_port_q]) begin
         eval_arm_q <= 1'b0;
         eval_q <= {in_cnt_q, 2'b00};
      end
   end

   // ==========================================================
   // Indirect access port: control, address, data
   logic [1:0] iap_cnt_q;
   logic [7:0] iap_ctl_q, iap_adr_q;
   logic [9:0] iap_addr;
   logic iap_go, iap_map, iap_cfg;
   assign iap_go = wr_en && address == pcmtss_pkg::ADDR_IAP && iap_cnt_q == 2'h2;
   assign iap_addr = {iap_ctl_q[5:4], iap_adr_q};
   assign iap_map = ~iap_ctl_q[6];
   assign iap_cfg = iap_ctl_q[6] & iap_ctl_q[1];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         iap_cnt_q <= 2'h0;
         iap_ctl_q <= 8'h0;
         iap_adr_q <= 8'h0;
      end else if (wr_en && address == pcmtss_pkg::ADDR_IAP) begin
         iap_cnt_q <= (iap_cnt_q == 2'h2) ? 2'h0 : iap_cnt_q + 2'h1;
         if (iap_cnt_q == 2'h0) iap_ctl_q <= wbyte;
         if (iap_cnt_q == 2'h1) iap_adr_q <= wbyte;
      end
   end

   // Slot map entry: {tristate, delay_select_bit, source channel}
   logic [11:0] map_q [pcmtss_pkg::CHANNELS];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (int l = 0; l < pcmtss_pkg::LINES; l++) offs_q[l] <= 2'h0;
         out_shift_q <= 8'h0;
         iap_rd_q <= 8'h0;
      end else if (iap_go) begin
         if (iap_ctl_q[7] && iap_cfg) begin
            if (iap_adr_q[3:0] == pcmtss_pkg::CFG_OUT_SHIFT) out_shift_q <= wbyte;
            else if (!iap_adr_q[3]) offs_q[iap_adr_q[2:0]] <= wbyte[1:0];
         end else if (!iap_ctl_q[7]) begin
            iap_rd_q <= iap_map ? map_q[iap_addr][7:0] : store_q[iap_ctl_q[0]][iap_addr];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (proc_q == pcmtss_pkg::pcmtss_clear) begin
         map_q[pidx] <= 12'h800;
      end else if (iap_go && iap_ctl_q[7] && iap_map) begin
         map_q[iap_addr] <= {iap_ctl_q[0], iap_ctl_q[1], iap_ctl_q[3:2], wbyte};
      end
   end

   always_ff @(posedge clock) begin
      if (proc_q == pcmtss_pkg::pcmtss_twrite) begin
         store_q[test_sel_q][pidx] <= pidx[7:0] ^ pcmtss_pkg::TEST_PATTERN;
      end else if (iap_go && iap_ctl_q[7] && !iap_map && !iap_cfg) begin
         store_q[iap_ctl_q[0]][iap_addr] <= wbyte;
      end else if (in_cnt_q[2:0] == pcmtss_pkg::BIT_LAST && proc_q == pcmtss_pkg::pcmtss_idle) begin
         for (int l = 0; l < pcmtss_pkg::LINES; l++) begin
            if (in_mask[l]) store_q[in_store_q][{in_cnt_q[9:3], 3'(l)}] <= {in_sh_q[l], in_bit[l]};
         end
      end
   end

   // ==========================================================
   // Output side: prefetch next slot's bytes at last bit of current slot
   logic [7:0] out_sh_q [pcmtss_pkg::LINES];
   logic [7:0] out_tri_q, pcm_out_q, pcm_out_oe_q;
   logic out_ptr;
   logic [6:0] next_slot;
   assign next_slot = out_cnt[9:3] + 7'h1;
   assign out_ptr = out_wrap ? (single ? 1'b0 : ~out_store_q) : out_store_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (int l = 0; l < pcmtss_pkg::LINES; l++) out_sh_q[l] <= 8'h0;
         out_tri_q <= 8'hff;
      end else if (out_cnt[2:0] == pcmtss_pkg::BIT_LAST) begin
         for (int l = 0; l < pcmtss_pkg::LINES; l++) begin
            logic [11:0] ent;
            logic sel;
            ent = map_q[{next_slot, 3'(l)}];
            if (single) sel = 1'b0;
            else if (!ent[10]) sel = ~out_ptr;
            else if ({1'b0, ent[9:0]} < in_pos) sel = in_store_q;
            else sel = ~in_store_q;
            out_sh_q[l] <= store_q[sel][ent[9:0]];
            out_tri_q[l] <= ent[11];
         end
      end else begin
         for (int l = 0; l < pcmtss_pkg::LINES; l++) out_sh_q[l] <= {out_sh_q[l][6:0], 1'b0};
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pcm_out_q <= 8'h0;
         pcm_out_oe_q <= 8'h0;
      end else begin
         for (int l = 0; l < pcmtss_pkg::LINES; l++) pcm_out_q[l] <= out_sh_q[l][7];
         pcm_out_oe_q <= {8{mode_q[pcmtss_pkg::MODE_OUT_ENABLE]}} & out_mask & ~out_tri_q;
      end
   end
   assign pcm_out = pcm_out_q;
   assign pcm_out_oe = pcm_out_oe_q;

   // ==========================================================
   // Status: sticky flags, hardware set wins over write-one clear
   logic stat_wr;
   assign stat_wr = wr_en && address == pcmtss_pkg::ADDR_STATUS;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sync_chg_q <= 1'b0;
         eval_done_q <= 1'b0;
      end else begin
         if (sync_evt) sync_chg_q <= 1'b1;
         else if (stat_wr && wbyte[pcmtss_pkg::STAT_SYNC_CHANGE]) sync_chg_q <= 1'b0;
         if (eval_arm_q && synced_q && fm_f_q[eval_port_q] && !fm_prev_q[eval_port_q])
            eval_done_q <= 1'b1;
         else if (stat_wr && wbyte[pcmtss_pkg::STAT_EVAL_DONE]) eval_done_q <= 1'b0;
      end
   end
   assign status_w = {2'b00, eval_done_q, test_ok_q, proc_q != pcmtss_pkg::pcmtss_idle,
                      iap_cnt_q != 2'h0, sync_chg_q, synced_q};
endmodule : pcmtss_switch

// >>> test/pcmtss_assertions.sv
// Purpose: Port checker for the PCM time-slot switch.
// Assumes: One bus request at a time, held until waitrequest is low.
// Notes: The mode byte is shadowed from accepted bus writes.
`timescale 1ns/1ps
module pcmtss_checker (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic [7:0] pcm_out_oe,
   input wire logic sync_change_pulse
);
   logic [7:0] mode_q;
   logic [7:0] mask;
   logic done;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // Mode shadow and expected drive mask
   assign done = read && !waitrequest;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= pcmtss_pkg::MODE_RESET;
      end else if (write && !waitrequest && byteenable[0]
                   && address == pcmtss_pkg::ADDR_MODE) begin
         mode_q <= writedata[7:0];
      end
   end
   assign mask = !mode_q[7] ? 8'h00 : (mode_q[1:0] == pcmtss_pkg::CAP_SMALL) ?
      pcmtss_pkg::OUT_MASK_SMALL : (mode_q[1:0] == pcmtss_pkg::CAP_HALF) ?
      pcmtss_pkg::OUT_MASK_HALF : pcmtss_pkg::MASK_ALL;
   // ==========================================================
   // Properties
   a_wait_one_cycle: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered after one wait cycle");
   a_idle_no_wait: assert property (!(read || write) |-> !waitrequest)
      else $error("waitrequest high with no request");
   a_read_upper_zero: assert property (done |-> readdata[31:12] == 20'h00000)
      else $error("read data upper bits not zero");
   a_unmapped_zero: assert property (done && address > 5'h10 |-> readdata == 32'h0)
      else $error("unmapped read not zero");
   a_cmd_reads_zero: assert property (done && address == pcmtss_pkg::ADDR_CMD
      |-> readdata == 32'h0)
      else $error("command register read not zero");
   a_eval_width: assert property (done && address == pcmtss_pkg::ADDR_EVAL
      |-> readdata[1:0] == 2'h0)
      else $error("evaluation low bits not zero");
   a_unused_float: assert property ($stable(mode_q) [*3] |-> (pcm_out_oe & ~mask) == 8'h00)
      else $error("unused output port driven");
   a_sync_one_cycle: assert property (sync_change_pulse |=> !sync_change_pulse)
      else $error("sync change pulse longer than one cycle");
endmodule : pcmtss_checker
bind pcmtss_switch pcmtss_checker i_pcmtss_checker (.clock(clock), .rst_n(rst_n),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
   .pcm_out_oe(pcm_out_oe), .sync_change_pulse(sync_change_pulse));

// >>> test/pcmtss_line_model.sv
// Purpose: PCM highway model: sync, measure pulses and serial input lines.
// Assumes: Frame of 1024 clocks, free running from reset release.
// Notes: Constant line data keeps checks independent of byte alignment.
`timescale 1ns/1ps
module pcmtss_line_model (
   input wire logic clock,
   input wire logic rst_n,
   output logic [7:0] pcm_in,
   output logic [7:0] frame_measure_input,
   output logic frame_sync_pulse
);
   logic [9:0] pos_q;
   // ==========================================================
   // Frame position
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pos_q <= 10'h000;
      end else begin
         pos_q <= pos_q + 10'h001;
      end
   end
   assign frame_sync_pulse = (pos_q < 10'h004);
   assign frame_measure_input = {8{pos_q >= 10'h12c && pos_q < 10'h130}};
   // Odd lines send all ones, even lines all zeros
   assign pcm_in = 8'haa;
endmodule : pcmtss_line_model

// >>> test/tb.sv
// Purpose: Self-checking bench for the PCM time-slot switch.
// Assumes: Line model drives the PCM side; bench is the Avalon-MM master.
// Notes: Self-test length shortened by parameter.
`timescale 1ns/1ps
module tb;
   localparam int ST_CYC = 3000;
   logic clock, rst_n, read, write, frame_sync_pulse, sync_change_pulse, waitrequest;
   logic [4:0] address;
   logic [31:0] writedata, readdata, d, e1;
   logic [3:0] byteenable;
   logic [7:0] pcm_in, frame_measure_input, pcm_out, pcm_out_oe, bits;
   int num_errors, compares, cycles, pulses, n;
   time t0;
   pcmtss_switch #(.SELF_TEST_CYCLES(ST_CYC)) i_pcmtss_switch (.clock(clock), .rst_n(rst_n),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .pcm_in(pcm_in), .frame_measure_input(frame_measure_input),
      .frame_sync_pulse(frame_sync_pulse), .pcm_out(pcm_out), .pcm_out_oe(pcm_out_oe),
      .sync_change_pulse(sync_change_pulse));
   pcmtss_line_model i_pcmtss_line_model (.clock(clock), .rst_n(rst_n), .pcm_in(pcm_in),
      .frame_measure_input(frame_measure_input), .frame_sync_pulse(frame_sync_pulse));
   // ==========================================================
   // Helpers
   task automatic finish_test();
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : finish_test
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic bus_write(input logic [4:0] a, input logic [7:0] v);
      address <= a;
      writedata <= {24'h000000, v};
      write <= 1'b1;
      @(posedge clock);
      while (waitrequest !== 1'b0) @(posedge clock);
      write <= 1'b0;
      @(posedge clock);
   endtask : bus_write
   task automatic bus_read(input logic [4:0] a, output logic [31:0] v);
      address <= a;
      read <= 1'b1;
      @(posedge clock);
      while (waitrequest !== 1'b0) @(posedge clock);
      v = readdata;
      read <= 1'b0;
      @(posedge clock);
   endtask : bus_read
   // Polls one status bit; the poll count bounds the wait
   task automatic wait_bit(input int b, input logic v);
      logic [31:0] s;
      bus_read(pcmtss_pkg::ADDR_STATUS, s);
      for (int i = 0; i < 4000 && s[b] !== v; i++) bus_read(pcmtss_pkg::ADDR_STATUS, s);
      check(s[b], v);
   endtask : wait_bit
   task automatic map(input logic [9:0] oc, input logic [9:0] src, input logic rd);
      bus_write(pcmtss_pkg::ADDR_IAP, {!rd, 1'b0, oc[9:8], src[9:8], 2'h0});
      bus_write(pcmtss_pkg::ADDR_IAP, oc[7:0]);
      bus_write(pcmtss_pkg::ADDR_IAP, src[7:0]);
   endtask : map
   // Skips one frame, then counts driven cycles of a line over one frame
   task automatic scan(input int ln);
      n = 0;
      bits = 8'h00;
      repeat (1024) @(posedge clock);
      repeat (1024) begin
         @(posedge clock);
         if (pcm_out_oe[ln] === 1'b1) begin
            n++;
            bits = {bits[6:0], pcm_out[ln]};
         end
      end
   endtask : scan
   // ==========================================================
   // Clock, timeout and sync event count
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (sync_change_pulse === 1'b1) pulses++;
      if (cycles == 90000) begin
         num_errors++;
         finish_test();
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      rst_n = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 5'h00;
      writedata = 32'h0;
      byteenable = 4'h1;
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      bus_read(pcmtss_pkg::ADDR_MODE, d);
      check(d, 32'h0);
      bus_read(pcmtss_pkg::ADDR_STATUS, d);
      check(d[4:3], 2'h2);
      bus_read(5'h14, d);
      check(d, 32'h0);
      bus_read(pcmtss_pkg::ADDR_CMD, d);
      check(d, 32'h0);
      bus_write(pcmtss_pkg::ADDR_CMD, 8'h01);
      bus_read(pcmtss_pkg::ADDR_STATUS, d);
      check(d[3], 1'b1);
      wait_bit(3, 1'b0);
      bus_write(pcmtss_pkg::ADDR_MODE, 8'h82);
      scan(2);
      check(n, 0);
      wait_bit(0, 1'b1);
      check(pulses > 0, 1'b1);
      bus_write(pcmtss_pkg::ADDR_IAP, 8'h80);
      bus_read(pcmtss_pkg::ADDR_STATUS, d);
      check(d[2], 1'b1);
      bus_write(pcmtss_pkg::ADDR_IAP, 8'h52);
      bus_write(pcmtss_pkg::ADDR_IAP, 8'h29);
      bus_read(pcmtss_pkg::ADDR_STATUS, d);
      check(d[2], 1'b0);
      map(10'h052, 10'h000, 1'b1);
      bus_read(pcmtss_pkg::ADDR_IAP, d);
      check(d[7:0], 8'h29);
      scan(2);
      check(n, 8);
      check(bits, 8'hff);
      bus_write(pcmtss_pkg::ADDR_IAP, 8'h82);
      bus_write(pcmtss_pkg::ADDR_IAP, 8'h52);
      bus_write(pcmtss_pkg::ADDR_IAP, 8'h29);
      scan(2);
      check(bits, 8'hff);
      bus_write(pcmtss_pkg::ADDR_MODE, 8'hc2);
      scan(2);
      check(bits, 8'hff);
      map(10'h052, 10'h02a, 1'b0);
      scan(2);
      check(bits, 8'h00);
      bus_write(pcmtss_pkg::ADDR_MODE, 8'h80);
      scan(2);
      check(n, 0);
      bus_write(pcmtss_pkg::ADDR_MODE, 8'h82);
      for (int k = 0; k < 2; k++) begin
         bus_write(pcmtss_pkg::ADDR_CMD, 8'h1b);
         wait_bit(5, 1'b1);
         bus_read(pcmtss_pkg::ADDR_EVAL, d);
         check(d[11:2] >= 10'h124 && d[11:2] <= 10'h134, 1'b1);
         if (k == 1) check(d, e1);
         e1 = d;
         bus_write(pcmtss_pkg::ADDR_STATUS, 8'h20);
         bus_read(pcmtss_pkg::ADDR_STATUS, d);
         check(d[5], 1'b0);
      end
      for (int k = 0; k < 2; k++) begin
         t0 = $time;
         bus_write(pcmtss_pkg::ADDR_CMD, k ? 8'h06 : 8'h02);
         wait_bit(3, 1'b0);
         check(($time - t0) / 10 >= ST_CYC, 1'b1);
         bus_read(pcmtss_pkg::ADDR_STATUS, d);
         check(d[4], 1'b1);
         scan(2);
         check(n, 0);
         map(10'h052, 10'h029, 1'b0);
      end
      finish_test();
   end
endmodule : tb
